/* File: logic/bhlp_pkg.sv */
package bhlp_pkg;

  // Core clock and link bit periods.
  localparam int CLK_NS      = 50;
  localparam int BIT_NS_SLOW = 100;
  localparam int BIT_NS_FAST = 50;
  localparam int CPB_SLOW    = (BIT_NS_SLOW + CLK_NS - 1) / CLK_NS;
  localparam int CPB_FAST    = (BIT_NS_FAST + CLK_NS - 1) / CLK_NS;
  localparam int TICK_W      = 2;
  localparam logic [TICK_W-1:0] CPB_SLOW_C = TICK_W'(CPB_SLOW);
  localparam logic [TICK_W-1:0] CPB_FAST_C = TICK_W'(CPB_FAST);

  // Handshake timing, in bit times (tenths where fractional).
  localparam int TLVVH_BITS   = 12;
  localparam int TAHVL_TENTHS = 18;
  localparam int TVLDX_BITS   = 11;

  // Packet layout: start, flag, eight data bits, stop.
  localparam int DATA_PKT_BITS = 11;
  localparam int ACK_PKT_BITS  = 2;
  localparam int RX_FLAG_SLOT  = 1;
  localparam int RX_STOP_SLOT  = 10;
  localparam logic BIT_START   = 1'b1;
  localparam logic BIT_DATA    = 1'b1;
  localparam logic BIT_ACK     = 1'b0;
  localparam logic BIT_STOP    = 1'b0;

  // Counts derived from the figures above; a partial first tick costs one more.
  localparam int CNT_W        = 4;
  localparam int SETUP_TICKS  = TLVVH_BITS - RX_STOP_SLOT + 1;
  localparam int AHVL_TICKS   = (TAHVL_TENTHS + 9) / 10 + 1;
  localparam int HOLD_TICKS   = TVLDX_BITS + 1;

  // Mode pin activity window: a pin tied to the 5 MHz reference toggles every 2 cycles.
  localparam int ACT_CYCLES = 8;
  localparam int ACT_W      = 4;

  // Synchroniser lanes.
  localparam int SYN_IVAL = 0;
  localparam int SYN_OUT_BYTE_ACK = 1;
  localparam int SYN_RX   = 2;
  localparam int SYN_MODE = 3;
  localparam int SYN_N    = 4;

  typedef enum logic [1:0] {IN_IDLE, IN_SEND, IN_ACK, IN_DROP} bhlp_in_t;
  typedef enum logic [2:0] {OUT_IDLE, OUT_SETUP, OUT_VALID, OUT_WAIT, OUT_HOLD} bhlp_out_t;

endpackage : bhlp_pkg

/* File: logic/bhlp_port.sv */
`timescale 1ns/100ps
// Functional notes
// - Serial transmit line low during reset.
// - Start sending byte within bit window.
// - Raise inbound ack within three bits.
// - Drop inbound ack one to four bits.
// - Outbound valid twelve bits after arrival.
// - Send ack packet within bit window.
// - Outbound valid stays 1.8 bits after ack.
// - Outbound byte held eleven bits after valid.
// - Next outbound valid waits ack low.
// - Mode pin selects rate or mode two.
module bhlp_port #(
  parameter int DATA_W    = 8,
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Mode and rate strap
  input  wire logic              mode_rate_select,
  // Inbound byte handshake
  input  wire logic [DATA_W-1:0] byte_in_bus,
  input  wire logic              in_byte_valid,
  output logic                   in_byte_ack,
  // Outbound byte handshake
  output logic      [DATA_W-1:0] byte_out_bus,
  output logic                   out_byte_valid,
  input  wire logic              out_byte_ack,
  // Serial link
  input  wire logic              serial_rx_line,
  output logic                   serial_tx_line,
  // Buffer status
  output logic                   rx_buf_ready
);

  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  logic [bhlp_pkg::SYN_N-1:0] sync1_q;
  logic [bhlp_pkg::SYN_N-1:0] sync2_q;
  logic                       mode_d1_q;
  logic [bhlp_pkg::ACT_W-1:0] act_q;
  logic                       fast;
  logic                       mode1;
  logic                       vs;
  logic                       qs;
  logic                       rx;
  logic [bhlp_pkg::TICK_W-1:0] cpb;
  logic [bhlp_pkg::TICK_W-1:0] tick_cnt_q;
  logic                        tick;
  logic [bhlp_pkg::DATA_PKT_BITS-1:0] tx_sr_q;
  logic [bhlp_pkg::CNT_W-1:0]  tx_left_q;
  logic                        tx_line_q;
  logic                        tx_busy;
  logic                        tx_start;
  logic                        tx_sel_ack;
  logic                        ack_req_q;
  logic                        data_req_q;
  logic                        ack_set;
  logic                        data_set;
  logic                        ack_pend;
  logic                        data_pend;
  logic [bhlp_pkg::TICK_W-1:0] rx_phase_q;
  logic [bhlp_pkg::CNT_W-1:0]  rx_slot_q;
  logic [DATA_W-1:0]           rx_sr_q;
  logic [DATA_W-1:0]           rx_data_q;
  logic                        rx_pend_q;
  logic                        ack_rx_q;
  logic                        rx_sample;
  logic [DATA_W-1:0]           buf_q [BUF_DEPTH];
  logic [PTR_W-1:0]            wr_ptr_q;
  logic [PTR_W-1:0]            rd_ptr_q;
  logic [PTR_W:0]              count_q;
  logic                        push;
  logic                        pop;
  logic                        buf_valid;
  bhlp_pkg::bhlp_in_t          in_state_q;
  logic                        in_ack_q;
  bhlp_pkg::bhlp_out_t         out_state_q;
  logic [bhlp_pkg::CNT_W-1:0]  out_cnt_q;
  logic [DATA_W-1:0]           out_data_q;
  logic                        out_valid_q;

  function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
    ptr_next = (p == PTR_W'(BUF_DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction : ptr_next

  // Two-flop synchronisers; only the second stage is used downstream.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {mode_rate_select, serial_rx_line, out_byte_ack, in_byte_valid};
      sync2_q <= sync1_q;
    end
  end

  assign vs = sync2_q[bhlp_pkg::SYN_IVAL];
  assign qs = sync2_q[bhlp_pkg::SYN_OUT_BYTE_ACK];
  assign rx = sync2_q[bhlp_pkg::SYN_RX];

  // A mode pin that keeps toggling is taken as tied to the reference clock.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_d1_q <= 1'b0;
      act_q     <= '0;
    end else begin
      mode_d1_q <= sync2_q[bhlp_pkg::SYN_MODE];
      if (mode_d1_q != sync2_q[bhlp_pkg::SYN_MODE]) begin
        act_q <= bhlp_pkg::ACT_W'(bhlp_pkg::ACT_CYCLES);
      end else if (act_q != '0) begin
        act_q <= act_q - bhlp_pkg::ACT_W'(1);
      end
    end
  end

  assign fast  = (act_q != '0);
  assign mode1 = fast | sync2_q[bhlp_pkg::SYN_MODE];
  assign cpb   = fast ? bhlp_pkg::CPB_FAST_C : bhlp_pkg::CPB_SLOW_C;

  // Bit timer; restarted when a packet starts so that its bits have full length.
  always_ff @(posedge clk) begin
    if (!rst_n || tx_start || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + bhlp_pkg::TICK_W'(1);
    end
  end

  assign tick = (tick_cnt_q == cpb - bhlp_pkg::TICK_W'(1));

  // Transmit arbitration: an ack goes ahead of a waiting byte, so the far end's sender is held
  // back by at most the one packet already on the line; a waiting byte follows it at once.
  assign ack_pend   = ack_req_q | ack_set;
  assign data_pend  = data_req_q | data_set;
  assign tx_busy    = (tx_left_q != '0);
  assign tx_start   = mode1 && !tx_busy && (ack_pend || data_pend);
  assign tx_sel_ack = ack_pend;

  always_ff @(posedge clk) begin
    if (!rst_n || !mode1) begin
      ack_req_q  <= 1'b0;
      data_req_q <= 1'b0;
    end else begin
      ack_req_q  <= ack_pend && !(tx_start && tx_sel_ack);
      data_req_q <= data_pend && !(tx_start && !tx_sel_ack);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !mode1) begin
      tx_sr_q   <= '0;
      tx_left_q <= '0;
      tx_line_q <= 1'b0;
    end else if (tx_start && tx_sel_ack) begin
      tx_line_q <= bhlp_pkg::BIT_START;
      tx_sr_q   <= bhlp_pkg::DATA_PKT_BITS'(bhlp_pkg::BIT_ACK);
      tx_left_q <= bhlp_pkg::CNT_W'(bhlp_pkg::ACK_PKT_BITS);
    end else if (tx_start) begin
      tx_line_q <= bhlp_pkg::BIT_START;
      tx_sr_q   <= bhlp_pkg::DATA_PKT_BITS'({1'b0, bhlp_pkg::BIT_STOP, byte_in_bus,
                                             bhlp_pkg::BIT_DATA});
      tx_left_q <= bhlp_pkg::CNT_W'(bhlp_pkg::DATA_PKT_BITS);
    end else if (tick && tx_busy) begin
      tx_line_q <= tx_sr_q[0];
      tx_sr_q   <= tx_sr_q >> 1;
      tx_left_q <= tx_left_q - bhlp_pkg::CNT_W'(1);
    end
  end

  assign serial_tx_line = tx_line_q;

  // Receiver: the start edge sets the phase, later bits are sampled one bit apart.
  assign rx_sample = (rx_slot_q != '0) && (rx_phase_q == cpb - bhlp_pkg::TICK_W'(1));

  always_ff @(posedge clk) begin
    if (!rst_n || !mode1) begin
      rx_phase_q <= '0;
      rx_slot_q  <= '0;
      rx_sr_q    <= '0;
      ack_rx_q   <= 1'b0;
    end else begin
      ack_rx_q <= 1'b0;
      if (rx_slot_q == '0) begin
        rx_phase_q <= '0;
        if (rx == bhlp_pkg::BIT_START) begin
          rx_slot_q <= bhlp_pkg::CNT_W'(bhlp_pkg::RX_FLAG_SLOT);
        end
      end else if (!rx_sample) begin
        rx_phase_q <= rx_phase_q + bhlp_pkg::TICK_W'(1);
      end else begin
        rx_phase_q <= '0;
        if (rx_slot_q == bhlp_pkg::CNT_W'(bhlp_pkg::RX_FLAG_SLOT) && rx == bhlp_pkg::BIT_ACK) begin
          ack_rx_q  <= 1'b1;
          rx_slot_q <= '0;
        end else if (rx_slot_q == bhlp_pkg::CNT_W'(bhlp_pkg::RX_STOP_SLOT)) begin
          rx_slot_q <= '0;
        end else begin
          if (rx_slot_q != bhlp_pkg::CNT_W'(bhlp_pkg::RX_FLAG_SLOT)) begin
            rx_sr_q <= {rx, rx_sr_q[DATA_W-1:1]};
          end
          rx_slot_q <= rx_slot_q + bhlp_pkg::CNT_W'(1);
        end
      end
    end
  end

  // A finished byte waits here until the buffer has room; the far end sends no second
  // byte before our ack, so this one register never overruns.
  always_ff @(posedge clk) begin
    if (!rst_n || !mode1) begin
      rx_pend_q <= 1'b0;
      rx_data_q <= '0;
    end else if (rx_sample && rx_slot_q == bhlp_pkg::CNT_W'(bhlp_pkg::RX_STOP_SLOT)) begin
      rx_pend_q <= 1'b1;
      rx_data_q <= rx_sr_q;
    end else if (push) begin
      rx_pend_q <= 1'b0;
    end
  end

  // Two-entry receive buffer.
  assign rx_buf_ready = (count_q != (PTR_W+1)'(BUF_DEPTH));
  assign push         = rx_pend_q && rx_buf_ready;
  assign buf_valid    = (count_q != '0);

  always_ff @(posedge clk) begin
    if (!rst_n || !mode1) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
      count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      buf_q[wr_ptr_q] <= rx_data_q;
    end
  end

  // Inbound handshake.
  assign data_set = (in_state_q == bhlp_pkg::IN_IDLE) && vs && mode1;

  always_ff @(posedge clk) begin
    if (!rst_n || !mode1) begin
      in_state_q <= bhlp_pkg::IN_IDLE;
      in_ack_q   <= 1'b0;
    end else begin
      case (in_state_q)
        bhlp_pkg::IN_IDLE: begin
          if (data_set) begin
            in_state_q <= bhlp_pkg::IN_SEND;
          end
        end
        bhlp_pkg::IN_SEND: begin
          if (ack_rx_q) begin
            in_ack_q   <= 1'b1;
            in_state_q <= bhlp_pkg::IN_ACK;
          end
        end
        bhlp_pkg::IN_ACK: begin
          if (!vs) begin
            in_state_q <= bhlp_pkg::IN_DROP;
          end
        end
        bhlp_pkg::IN_DROP: begin
          if (tick) begin
            in_ack_q   <= 1'b0;
            in_state_q <= bhlp_pkg::IN_IDLE;
          end
        end
        default: begin
          in_state_q <= bhlp_pkg::IN_IDLE;
          in_ack_q   <= 1'b0;
        end
      endcase
    end
  end

  assign in_byte_ack = in_ack_q;

  // Outbound handshake.
  assign pop     = (out_state_q == bhlp_pkg::OUT_IDLE) && buf_valid && !qs && mode1;
  assign ack_set = (out_state_q == bhlp_pkg::OUT_VALID) && qs;

  always_ff @(posedge clk) begin
    if (!rst_n || !mode1) begin
      out_state_q <= bhlp_pkg::OUT_IDLE;
      out_cnt_q   <= '0;
      out_data_q  <= '0;
      out_valid_q <= 1'b0;
    end else begin
      case (out_state_q)
        bhlp_pkg::OUT_IDLE: begin
          if (pop) begin
            out_data_q  <= buf_q[rd_ptr_q];
            out_cnt_q   <= bhlp_pkg::CNT_W'(bhlp_pkg::SETUP_TICKS);
            out_state_q <= bhlp_pkg::OUT_SETUP;
          end
        end
        bhlp_pkg::OUT_SETUP: begin
          if (tick) begin
            out_cnt_q <= out_cnt_q - bhlp_pkg::CNT_W'(1);
            if (out_cnt_q == bhlp_pkg::CNT_W'(1)) begin
              out_valid_q <= 1'b1;
              out_state_q <= bhlp_pkg::OUT_VALID;
            end
          end
        end
        bhlp_pkg::OUT_VALID: begin
          if (ack_set) begin
            out_cnt_q   <= bhlp_pkg::CNT_W'(bhlp_pkg::AHVL_TICKS);
            out_state_q <= bhlp_pkg::OUT_WAIT;
          end
        end
        bhlp_pkg::OUT_WAIT: begin
          if (tick) begin
            out_cnt_q <= out_cnt_q - bhlp_pkg::CNT_W'(1);
            if (out_cnt_q == bhlp_pkg::CNT_W'(1)) begin
              out_valid_q <= 1'b0;
              out_cnt_q   <= bhlp_pkg::CNT_W'(bhlp_pkg::HOLD_TICKS);
              out_state_q <= bhlp_pkg::OUT_HOLD;
            end
          end
        end
        bhlp_pkg::OUT_HOLD: begin
          if (tick) begin
            out_cnt_q <= out_cnt_q - bhlp_pkg::CNT_W'(1);
            if (out_cnt_q == bhlp_pkg::CNT_W'(1)) begin
              out_state_q <= bhlp_pkg::OUT_IDLE;
            end
          end
        end
        default: begin
          out_state_q <= bhlp_pkg::OUT_IDLE;
          out_valid_q <= 1'b0;
        end
      endcase
    end
  end

  assign byte_out_bus   = out_data_q;
  assign out_byte_valid = out_valid_q;

endmodule : bhlp_port

/* File: verif/bhlp_port_assertions.sv */
`timescale 1ns/100ps
module bhlp_port_assertions #(
  parameter int DATA_W = 8
) (
  // Clock, reset and mode
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              mode_rate_select,
  // Inbound handshake
  input wire logic [DATA_W-1:0] byte_in_bus,
  input wire logic              in_byte_valid,
  input wire logic              in_byte_ack,
  // Outbound handshake
  input wire logic [DATA_W-1:0] byte_out_bus,
  input wire logic              out_byte_valid,
  input wire logic              out_byte_ack,
  // Link and status
  input wire logic              serial_rx_line,
  input wire logic              serial_tx_line,
  input wire logic              rx_buf_ready
);
  logic [4:0] hold_q;
  logic [1:0] mode_on_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Counts the clocks for which the outbound byte must outlive its valid flag.
  always_ff @(posedge clk) begin
    if (!rst_n) hold_q <= 5'h00;
    else if ($fell(out_byte_valid)) hold_q <= 5'h16;
    else if (hold_q != 5'h00) hold_q <= hold_q - 5'h01;
  end
  // The port only serves bytes in mode 1, so a strobe seen in mode 2 starts no check.
  always_ff @(posedge clk) begin
    if (!rst_n) mode_on_q <= 2'h0;
    else if (mode_rate_select) mode_on_q <= 2'h3;
    else if (mode_on_q != 2'h0) mode_on_q <= mode_on_q - 2'h1;
  end
  a_tx_reset_low: assert property (disable iff (1'b0) !rst_n |=> !serial_tx_line)
    else $error("tx line high in reset");
  a_tx_start_win: assert property ($rose(in_byte_valid) && !in_byte_ack && mode_on_q != 2'h0
    |-> ##[1:8] $rose(serial_tx_line))
    else $error("byte not started in time");
  a_in_ack_hold: assert property (in_byte_ack && in_byte_valid |=> in_byte_ack)
    else $error("in ack dropped early");
  a_in_ack_drop: assert property ($fell(in_byte_valid) && in_byte_ack |-> ##[1:8] !in_byte_ack)
    else $error("in ack not dropped");
  a_out_setup: assert property ($rose(out_byte_valid) |-> $stable(byte_out_bus))
    else $error("out byte not set up");
  a_ack_pkt_win: assert property ($rose(out_byte_ack) && out_byte_valid |-> ##[1:26] $rose(serial_tx_line))
    else $error("ack packet late");
  a_out_vld_min: assert property ($rose(out_byte_ack) && out_byte_valid |-> out_byte_valid[*4])
    else $error("out valid dropped early");
  a_out_hold: assert property (hold_q != 5'h00 |-> $stable(byte_out_bus))
    else $error("out byte not held");
  a_next_wait: assert property ($rose(out_byte_valid) |-> !out_byte_ack && !$past(out_byte_ack))
    else $error("out valid with ack high");
  a_mode_two_idle: assert property (!mode_rate_select[*8] ##1 !mode_rate_select[*4] |-> !serial_tx_line && !in_byte_ack && !out_byte_valid)
    else $error("active in mode two");
endmodule : bhlp_port_assertions
bind bhlp_port bhlp_port_assertions #(.DATA_W(DATA_W)) u_bhlp_port_assertions (
  .clk(clk), .rst_n(rst_n), .mode_rate_select(mode_rate_select),
  .byte_in_bus(byte_in_bus), .in_byte_valid(in_byte_valid), .in_byte_ack(in_byte_ack),
  .byte_out_bus(byte_out_bus), .out_byte_valid(out_byte_valid), .out_byte_ack(out_byte_ack),
  .serial_rx_line(serial_rx_line), .serial_tx_line(serial_tx_line), .rx_buf_ready(rx_buf_ready)
);

/* File: verif/bhlp_link_model.sv */
`timescale 1ns/100ps
module bhlp_link_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Serial link
  input  wire logic       serial_tx_line,
  output logic            serial_rx_line,
  // Bench control
  input  wire logic       push,
  input  wire logic [7:0] push_byte,
  input  wire logic [3:0] ack_wait,
  output logic      [7:0] got_byte,
  output int              got_cnt,
  output int              ack_cnt
);
  logic [7:0] q[$];
  int         ack_due = 0;
  int         sent = 0;
  always @(posedge clk) begin
    if (push) q.push_back(push_byte);
  end
  task automatic put(input logic v);
    serial_rx_line <= v;
    repeat (2) @(posedge clk);
  endtask : put
  // Acks go first; a new byte waits for the ack of the last one, as the link demands.
  initial begin : sender
    logic [7:0] b;
    serial_rx_line = 1'b0;
    forever begin
      @(posedge clk);
      if (rst_n && ack_due > 0) begin
        ack_due--;
        put(1'b1);
        put(1'b0);
      end else if (rst_n && q.size() > 0 && ack_cnt == sent) begin
        b = q.pop_front();
        sent++;
        put(1'b1);
        put(1'b1);
        for (int i = 0; i < 8; i++) put(b[i]);
        put(1'b0);
      end
    end
  end
  initial begin : receiver
    logic [7:0] b;
    got_byte = 8'h00;
    got_cnt = 0;
    ack_cnt = 0;
    forever begin
      @(posedge clk);
      if (serial_tx_line === 1'b1) begin
        repeat (2) @(posedge clk);
        if (serial_tx_line === 1'b1) begin
          for (int i = 0; i < 8; i++) begin
            repeat (2) @(posedge clk);
            b[i] = serial_tx_line;
          end
          repeat (2) @(posedge clk);
          got_byte = b;
          got_cnt++;
          fork
            begin
              repeat (ack_wait) @(posedge clk);
              ack_due++;
            end
          join_none
        end else begin
          ack_cnt++;
        end
      end
    end
  end
endmodule : bhlp_link_model

/* File: verif/bhlp_port_tb.sv */
`timescale 1ns/100ps
module bhlp_port_tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       mode_rate_select = 1'b0;
  logic [7:0] byte_in_bus = 8'h00;
  logic       in_byte_valid = 1'b0;
  logic       in_byte_ack;
  logic [7:0] byte_out_bus;
  logic       out_byte_valid;
  logic       out_byte_ack = 1'b0;
  logic       serial_rx_line;
  logic       serial_tx_line;
  logic       rx_buf_ready;
  logic       push = 1'b0;
  logic [7:0] push_byte = 8'h00;
  logic [3:0] ack_wait = 4'h0;
  logic [7:0] got_byte;
  logic [1:0] obs;
  int         got_cnt;
  int         ack_cnt;
  int         mismatches = 0;
  int         check_count = 0;
  int         cycles = 0;
  always #25 clk = ~clk;
  assign obs = {out_byte_valid, in_byte_ack};
  bhlp_port u_bhlp_port (
    .clk(clk), .rst_n(rst_n), .mode_rate_select(mode_rate_select),
    .byte_in_bus(byte_in_bus), .in_byte_valid(in_byte_valid), .in_byte_ack(in_byte_ack),
    .byte_out_bus(byte_out_bus), .out_byte_valid(out_byte_valid), .out_byte_ack(out_byte_ack),
    .serial_rx_line(serial_rx_line), .serial_tx_line(serial_tx_line), .rx_buf_ready(rx_buf_ready)
  );
  bhlp_link_model u_bhlp_link_model (
    .clk(clk), .rst_n(rst_n), .serial_tx_line(serial_tx_line), .serial_rx_line(serial_rx_line),
    .push(push), .push_byte(push_byte), .ack_wait(ack_wait), .got_byte(got_byte),
    .got_cnt(got_cnt), .ack_cnt(ack_cnt)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic wait_lvl(input int i, input logic lvl, output int n);
    n = 0;
    while (obs[i] !== lvl && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_lvl
  task automatic send_link(input logic [7:0] b);
    push_byte <= b;
    push <= 1'b1;
    @(posedge clk);
    push <= 1'b0;
    @(posedge clk);
  endtask : send_link
  task automatic t_send(input logic [7:0] b);
    int n;
    int c0;
    c0 = got_cnt;
    byte_in_bus <= b;
    @(posedge clk);
    in_byte_valid <= 1'b1;
    wait_lvl(0, 1'b1, n);
    check(got_byte, b);
    check(got_cnt, c0 + 1);
    in_byte_valid <= 1'b0;
    byte_in_bus <= ~b;
    wait_lvl(0, 1'b0, n);
    check(n >= 2 && n <= 8, 1'b1);
  endtask : t_send
  // Holds the ack long past the hold time so that an early next byte would show.
  task automatic take(input logic [7:0] b);
    int n;
    int a0;
    a0 = ack_cnt;
    check(byte_out_bus, b);
    out_byte_ack <= 1'b1;
    wait_lvl(1, 1'b0, n);
    check(n >= 4, 1'b1);
    repeat (21) @(posedge clk);
    check(byte_out_bus, b);
    check(ack_cnt, a0 + 1);
    repeat (40) @(posedge clk);
    check(out_byte_valid, 1'b0);
    check(rx_buf_ready, 1'b1);
    out_byte_ack <= 1'b0;
  endtask : take
  task automatic t_recv(input logic [7:0] b);
    int n;
    send_link(b);
    wait_lvl(1, 1'b1, n);
    check(n >= 22, 1'b1);
    take(b);
  endtask : t_recv
  task automatic t_buffer;
    int n;
    send_link(8'hC3);
    send_link(8'h3A);
    wait_lvl(1, 1'b1, n);
    repeat (80) @(posedge clk);
    check(out_byte_valid, 1'b1);
    take(8'hC3);
    wait_lvl(1, 1'b1, n);
    take(8'h3A);
  endtask : t_buffer
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    repeat (32) @(posedge clk);
    check(serial_tx_line, 1'b0);
    check(in_byte_ack, 1'b0);
    rst_n <= 1'b1;
    in_byte_valid <= 1'b1;
    repeat (16) @(posedge clk);
    check(serial_tx_line, 1'b0);
    check(in_byte_ack, 1'b0);
    in_byte_valid <= 1'b0;
    mode_rate_select <= 1'b1;
    repeat (16) @(posedge clk);
    t_send(8'hA5);
    t_send(8'h3C);
    ack_wait <= 4'h6;
    t_send(8'h00);
    ack_wait <= 4'h0;
    t_recv(8'h5A);
    t_buffer();
    fork
      t_send(8'hFF);
      t_recv(8'h81);
    join
    wrap_up();
  end
endmodule : bhlp_port_tb
